// file: hdl/cdp_pkg.sv
// Constants and carriers for the 64 kbit/s codirectional slot adapter.
// Assumes one system clock; every line-side clock arrives as a sampled input.
package cdp_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] CDP_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CDP_ADDR_STAT = 8'h04;
  localparam logic [5:0] CDP_CTRL_RESET = 6'h13;
  localparam int CDP_STAT_ALARM = 0;
  localparam int CDP_STAT_SEEK = 1;
  localparam int CDP_STAT_TX_IDLE = 2;
  localparam int CDP_STAT_TX_REPEAT = 3;
  localparam logic [1:0] CDP_RESP_OKAY = 2'h0;
  localparam logic [1:0] CDP_RESP_SLVERR = 2'h2;

  // ==========================================================
  // Sampled input lanes
  localparam int CDP_IN_W = 11;
  localparam int CDP_IN_TXBCK = 0;
  localparam int CDP_IN_TXLCK = 1;
  localparam int CDP_IN_RXBCK = 2;
  localparam int CDP_IN_RECCK = 3;
  localparam int CDP_IN_TXDAT = 4;
  localparam int CDP_IN_TXSA = 5;
  localparam int CDP_IN_TXSB = 6;
  localparam int CDP_IN_RXSA = 7;
  localparam int CDP_IN_RXSB = 8;
  localparam int CDP_IN_RXP = 9;
  localparam int CDP_IN_RXN = 10;

  // ==========================================================
  // Line timing in recovery-clock ticks, unit intervals, bit indices and octet counts
  localparam logic [4:0] CDP_BIT_LAST = 5'h1F;
  localparam logic [4:0] CDP_SEEK_LAST = 5'h0F;
  localparam logic [4:0] CDP_POL_TICK = 5'h04;
  localparam logic [4:0] CDP_DAT_TICK = 5'h14;
  localparam logic [4:0] CDP_MID_TICK = 5'h10;
  localparam logic [4:0] CDP_LOCK_WIN = 5'h03;
  localparam logic [1:0] CDP_UI_LAST = 2'h3;
  localparam logic [2:0] CDP_BIT_IDX_LAST = 3'h7;
  localparam logic [2:0] CDP_VIOL_PREV = 3'h6;
  localparam logic [3:0] CDP_MISS_LIMIT = 4'h8;

  typedef struct packed {
    logic rec_src_bit;
    logic octet_lock_blank_enable;
    logic force_blank;
    logic tx_send_alarm;
    logic rx_slot_pick;
    logic tx_slot_pick;
  } cdp_ctrl_s;

  typedef struct packed {
    logic blank;
    logic [7:0] data;
  } cdp_octet_s;
endpackage : cdp_pkg

// file: hdl/cdp_sync3.sv
// Three-stage synchroniser with agreement filter and edge pulses.
// Assumes inputs are asynchronous levels; outputs are in the aclk domain.
`timescale 1ns/1ns
`default_nettype none
module cdp_sync3 #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
      level <= '0;
    end else begin
      ff1 <= d;
      ff2 <= ff1;
      ff3 <= ff2;
      level <= (ff2 & ff3) | (level & (ff2 | ff3));
    end
  end

  assign rise = ff2 & ff3 & ~level;
  assign fall = ~ff2 & ~ff3 & level;
endmodule : cdp_sync3
`default_nettype wire

// file: hdl/cdp_clk_recover.sv
// Bit timing recovery: variable-length tick counter resynchronised on marks.
// Assumes tick and onset are single-cycle pulses in the aclk domain.
`timescale 1ns/1ns
`default_nettype none
module cdp_clk_recover
  import cdp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic onset,
  output logic pol_strobe,
  output logic dat_strobe,
  output logic seek
);
  logic [4:0] cnt;
  logic pend;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend <= 1'b0;
    end else begin
      pend <= onset | (pend & ~tick);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 5'h00;
      seek <= 1'b1;
    end else if (tick) begin
      if (pend && (seek || cnt >= CDP_BIT_LAST - CDP_LOCK_WIN || cnt <= CDP_LOCK_WIN)) begin
        cnt <= 5'h01;
        seek <= 1'b0;
      end else if (pend && !seek && cnt != CDP_MID_TICK && cnt != CDP_MID_TICK + 5'h01) begin
        cnt <= 5'h00;
        seek <= 1'b1;
      end else if (seek) begin
        cnt <= (cnt >= CDP_SEEK_LAST) ? 5'h00 : cnt + 5'h01;
      end else begin
        cnt <= (cnt == CDP_BIT_LAST) ? 5'h00 : cnt + 5'h01;
      end
    end
  end

  assign pol_strobe = tick & ~seek & (cnt == CDP_POL_TICK);
  assign dat_strobe = tick & ~seek & (cnt == CDP_DAT_TICK);
endmodule : cdp_clk_recover
`default_nettype wire

// file: hdl/cdp_adapter.sv
// Codirectional 64 kbit/s line code to PCM time-slot adapter, both ways.
// Assumes all line and slot pins are asynchronous to aclk and much slower.
// Operation
// - Transmit envelope is slot A when the transmit pick is high, else slot B.
// - Eight bits sampled on bit-clock rises inside envelope, then latched.
// - Latch moves to output register only after previous octet fully sent.
// - Zero bit sends 0101, one bit 0011 on active-low rails.
// - Each bit takes exactly four line-clock periods.
// - Successive bit blocks alternate between positive and negative rail.
// - Seventh and eighth blocks share polarity, marking the octet end.
// - Send-alarm suppresses the octet violation, keeping plain alternation.
// - Missing octet repeated once, then both rails held high.
// - New octet arriving before transfer overwrites the stored one.
// - Receiver decodes rails with recovered timing into two ping-pong registers.
// - Eight bits shifted out on receive bit-clock rises inside envelope.
// - Receive envelope is slot A when the receive pick is high, else B.
// - Serial output changes only within the selected envelope, glitch free.
// - Recovery counter runs on recovery or bit clock, resynced by marks.
// - On lost sync the counter shortens and seeks the next transition.
// - Violations mark octet ends; otherwise timing continues from the last.
// - With supervision low, a missing violation blanks the output high.
// - Eight consecutive missing violations raise the octet alarm.
// - Forced blank drives all ones in the slot.
// - Slow reader drops octets, fast reader repeats the last, alignment kept.
// - Transmitter repeats or drops whole octets only, never partial ones.
`timescale 1ns/1ns
`default_nettype none
module cdp_adapter
  import cdp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_tdm_serial_in,
  input wire logic tx_bit_clock,
  input wire logic tx_slot_a,
  input wire logic tx_slot_b,
  input wire logic tx_line_clock,
  output logic tx_pos_n,
  output logic tx_neg_n,
  input wire logic rx_pos_n,
  input wire logic rx_neg_n,
  input wire logic rx_recovery_clock,
  input wire logic rx_bit_clock,
  input wire logic rx_slot_a,
  input wire logic rx_slot_b,
  output logic rx_tdm_serial_out,
  output logic octet_alarm
);
  // ==========================================================
  // Input sampling
  logic [CDP_IN_W-1:0] in_lvl;
  logic [CDP_IN_W-1:0] in_rise;
  logic [CDP_IN_W-1:0] in_fall;
  cdp_ctrl_s ctrl;

  cdp_sync3 #(.W(CDP_IN_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    // Rails inverted so an idle line matches the reset level, no false edge
    .d({~rx_neg_n, ~rx_pos_n, rx_slot_b, rx_slot_a, tx_slot_b, tx_slot_a, tx_tdm_serial_in,
        rx_recovery_clock, rx_bit_clock, tx_line_clock, tx_bit_clock}),
    .level(in_lvl),
    .rise(in_rise),
    .fall(in_fall)
  );

  logic tx_env;
  logic rx_env;
  logic tx_bit_rise;
  logic tx_line_rise;
  logic rx_bit_rise;
  assign tx_env = ctrl.tx_slot_pick ? in_lvl[CDP_IN_TXSA] : in_lvl[CDP_IN_TXSB];
  // Envelope counts from its rise pulse, so a clock rise arriving with it is seen
  assign rx_env = ctrl.rx_slot_pick ? (in_lvl[CDP_IN_RXSA] | in_rise[CDP_IN_RXSA])
                                    : (in_lvl[CDP_IN_RXSB] | in_rise[CDP_IN_RXSB]);
  assign tx_bit_rise = in_rise[CDP_IN_TXBCK];
  assign tx_line_rise = in_rise[CDP_IN_TXLCK];
  assign rx_bit_rise = in_rise[CDP_IN_RXBCK];

  // Mark pattern of one bit block, unit interval ui (active high)
  function automatic logic code_mark(input logic b, input logic [1:0] ui);
    code_mark = b ? (ui < 2'h2) : ~ui[0];
  endfunction : code_mark

  // ==========================================================
  // Transmit input register and storage latch
  logic [7:0] tx_in_sh;
  logic [2:0] tx_in_cnt;
  logic [7:0] tx_latch;
  logic tx_latch_full;
  logic tx_oct_done;
  logic tx_load;
  assign tx_oct_done = tx_bit_rise & tx_env & (tx_in_cnt == CDP_BIT_IDX_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_in_sh <= 8'h00;
      tx_in_cnt <= 3'h0;
    end else if (!tx_env) begin
      tx_in_cnt <= 3'h0;
    end else if (tx_bit_rise) begin
      tx_in_sh <= {tx_in_sh[6:0], in_lvl[CDP_IN_TXDAT]};
      tx_in_cnt <= tx_in_cnt + 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_latch <= 8'h00;
      tx_latch_full <= 1'b0;
    end else if (tx_oct_done) begin
      tx_latch <= {tx_in_sh[6:0], in_lvl[CDP_IN_TXDAT]};
      tx_latch_full <= 1'b1;
    end else if (tx_load) begin
      tx_latch_full <= 1'b0;
    end
  end

  // ==========================================================
  // Transmit line encoder
  logic [7:0] tx_out_sh;
  logic [1:0] tx_ui;
  logic [2:0] tx_bit;
  logic tx_pol;
  logic tx_sending;
  logic tx_rep_used;
  logic tx_repeat_seen;
  logic tx_blk_end;
  logic tx_oct_end;
  assign tx_blk_end = tx_line_rise & (tx_ui == CDP_UI_LAST);
  assign tx_oct_end = tx_blk_end & (tx_bit == CDP_BIT_IDX_LAST);
  assign tx_load = tx_line_rise & tx_latch_full & (!tx_sending || tx_oct_end);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_ui <= 2'h0;
      tx_bit <= 3'h0;
    end else if (tx_line_rise && !tx_sending) begin
      tx_ui <= 2'h0;
      tx_bit <= 3'h0;
    end else if (tx_line_rise) begin
      tx_ui <= tx_ui + 2'h1;
      if (tx_ui == CDP_UI_LAST) begin
        tx_bit <= tx_bit + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_out_sh <= 8'h00;
      tx_sending <= 1'b0;
      tx_rep_used <= 1'b0;
      tx_repeat_seen <= 1'b0;
    end else if (tx_load) begin
      tx_out_sh <= tx_latch;
      tx_sending <= 1'b1;
      tx_rep_used <= 1'b0;
    end else if (tx_oct_end) begin
      if (!tx_rep_used) begin
        tx_rep_used <= 1'b1;
        tx_repeat_seen <= 1'b1;
      end else begin
        tx_sending <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pol <= 1'b0;
    end else if (tx_blk_end && tx_sending) begin
      if (tx_bit == CDP_VIOL_PREV && !ctrl.tx_send_alarm) begin
        tx_pol <= tx_pol;
      end else begin
        tx_pol <= ~tx_pol;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pos_n <= 1'b1;
      tx_neg_n <= 1'b1;
    end else begin
      tx_pos_n <= ~(tx_sending & tx_pol & code_mark(tx_out_sh[~tx_bit], tx_ui));
      tx_neg_n <= ~(tx_sending & ~tx_pol & code_mark(tx_out_sh[~tx_bit], tx_ui));
    end
  end

  // ==========================================================
  // Receive clock recovery and decoder
  logic pol_strobe;
  logic dat_strobe;
  logic rec_seek;
  logic rx_rail_act;
  logic rx_pol_pos;
  logic rx_prev_pol;
  logic rx_have_prev;
  logic rx_bit;
  logic rx_viol;

  cdp_clk_recover u_rec (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(ctrl.rec_src_bit ? in_rise[CDP_IN_RXBCK] : in_rise[CDP_IN_RECCK]),
    .onset(in_rise[CDP_IN_RXP] | in_rise[CDP_IN_RXN]),
    .pol_strobe(pol_strobe),
    .dat_strobe(dat_strobe),
    .seek(rec_seek)
  );

  assign rx_rail_act = in_lvl[CDP_IN_RXP] | in_lvl[CDP_IN_RXN];
  assign rx_bit = ~rx_rail_act;
  assign rx_viol = rx_have_prev & (rx_pol_pos == rx_prev_pol);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_pol_pos <= 1'b0;
      rx_prev_pol <= 1'b0;
      rx_have_prev <= 1'b0;
    end else if (rec_seek) begin
      rx_have_prev <= 1'b0;
    end else if (pol_strobe) begin
      rx_pol_pos <= in_lvl[CDP_IN_RXP];
    end else if (dat_strobe) begin
      rx_prev_pol <= rx_pol_pos;
      rx_have_prev <= 1'b1;
    end
  end

  // ==========================================================
  // Receive octet alignment and supervision
  logic [7:0] rx_sh;
  logic [2:0] rx_idx;
  logic [3:0] rx_miss;
  logic rx_oct_done;
  logic rx_oct_missing;
  assign rx_oct_done = dat_strobe & (rx_viol | (rx_idx == CDP_BIT_IDX_LAST));
  assign rx_oct_missing = rx_oct_done & ~rx_viol;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sh <= 8'h00;
      rx_idx <= 3'h0;
    end else if (dat_strobe) begin
      rx_sh <= {rx_sh[6:0], rx_bit};
      rx_idx <= rx_viol ? 3'h0 : rx_idx + 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_miss <= 4'h0;
      octet_alarm <= 1'b0;
    end else if (rx_oct_done && rx_viol) begin
      rx_miss <= 4'h0;
      octet_alarm <= 1'b0;
    end else if (rx_oct_missing && rx_miss != CDP_MISS_LIMIT) begin
      rx_miss <= rx_miss + 4'h1;
      octet_alarm <= (rx_miss + 4'h1 == CDP_MISS_LIMIT);
    end
  end

  // ==========================================================
  // Ping-pong storage and slot readout
  cdp_octet_s rx_bank [2];
  logic rx_rd_bank;
  logic rx_new;
  logic rx_take;
  logic [7:0] rx_out_sh;
  logic rx_out_blank;
  logic [2:0] rx_out_idx;
  cdp_octet_s rx_pick;
  assign rx_take = rx_bit_rise & rx_env & (rx_out_idx == 3'h0);
  assign rx_pick = rx_bank[rx_new ? ~rx_rd_bank : rx_rd_bank];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_bank[0] <= '{blank: 1'b1, data: 8'hFF};
      rx_bank[1] <= '{blank: 1'b1, data: 8'hFF};
    end else if (rx_oct_done) begin
      // Unread octet in the write bank is overwritten when the reader lags
      rx_bank[~rx_rd_bank] <= '{blank: rx_oct_missing & ~ctrl.octet_lock_blank_enable,
                                data: {rx_sh[6:0], rx_bit}};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_rd_bank <= 1'b0;
      rx_new <= 1'b0;
    end else begin
      if (rx_take && rx_new) begin
        rx_rd_bank <= ~rx_rd_bank;
      end
      // Octet landing in the bank swapped in at a take is kept there as the newest
      rx_new <= (rx_oct_done & ~(rx_take & rx_new)) | (rx_new & ~rx_take);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_out_sh <= 8'hFF;
      rx_out_blank <= 1'b1;
      rx_out_idx <= 3'h0;
      rx_tdm_serial_out <= 1'b1;
    end else if (!rx_env) begin
      rx_out_idx <= 3'h0;
    end else if (rx_bit_rise) begin
      rx_out_idx <= rx_out_idx + 3'h1;
      if (rx_take) begin
        rx_out_sh <= {rx_pick.data[6:0], 1'b1};
        rx_out_blank <= rx_pick.blank;
        rx_tdm_serial_out <= rx_pick.data[7] | rx_pick.blank | ctrl.force_blank;
      end else begin
        rx_out_sh <= {rx_out_sh[6:0], 1'b1};
        rx_tdm_serial_out <= rx_out_sh[7] | rx_out_blank | ctrl.force_blank;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite register slave
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_got;
  logic w_got;
  logic [31:0] stat_word;
  always_comb begin
    stat_word = 32'h00000000;
    stat_word[CDP_STAT_ALARM] = octet_alarm;
    stat_word[CDP_STAT_SEEK] = rec_seek;
    stat_word[CDP_STAT_TX_IDLE] = ~tx_sending;
    stat_word[CDP_STAT_TX_REPEAT] = tx_repeat_seen;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CDP_RESP_OKAY;
      ctrl <= CDP_CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == CDP_ADDR_CTRL) begin
          s_axi_bresp <= CDP_RESP_OKAY;
          if (w_strb[0]) begin
            ctrl <= w_data[5:0];
          end
        end else if (aw_addr == CDP_ADDR_STAT) begin
          s_axi_bresp <= CDP_RESP_OKAY;
        end else begin
          s_axi_bresp <= CDP_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= CDP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == CDP_ADDR_CTRL) begin
        s_axi_rdata <= {26'h0, ctrl};
        s_axi_rresp <= CDP_RESP_OKAY;
      end else if (s_axi_araddr == CDP_ADDR_STAT) begin
        s_axi_rdata <= stat_word;
        s_axi_rresp <= CDP_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= CDP_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_blk_end_at(logic [2:0] b);
    tx_line_rise && tx_sending && tx_ui == CDP_UI_LAST && tx_bit == b;
  endsequence

  sequence s_slot_bit;
    rx_bit_rise && rx_env;
  endsequence

  tx_viol_keep_a: assert property (
    s_blk_end_at(CDP_VIOL_PREV) ##0 !ctrl.tx_send_alarm |=> tx_pol == $past(tx_pol))
    else $error("octet violation block changed polarity");
  tx_alternate_a: assert property (
    tx_blk_end && tx_sending && (tx_bit != CDP_VIOL_PREV || ctrl.tx_send_alarm) |=> tx_pol != $past(tx_pol))
    else $error("bit blocks did not alternate");
  tx_ui_hold_a: assert property (
    !tx_line_rise |=> $stable(tx_ui))
    else $error("unit interval moved without line clock");
  tx_idle_high_a: assert property (
    !tx_sending ##1 !tx_sending |-> tx_pos_n && tx_neg_n)
    else $error("rails not high while idle");
  tx_latch_set_a: assert property (
    tx_oct_done |=> tx_latch_full && tx_latch == $past({tx_in_sh[6:0], in_lvl[CDP_IN_TXDAT]}))
    else $error("new octet not stored");
  rx_out_stable_a: assert property (
    !rx_env |=> $stable(rx_tdm_serial_out))
    else $error("serial output changed outside slot");
  rx_force_blank_a: assert property (
    s_slot_bit ##0 ctrl.force_blank |=> rx_tdm_serial_out)
    else $error("forced blank not all ones");
  rx_alarm_set_a: assert property (
    rx_oct_missing && rx_miss == CDP_MISS_LIMIT - 4'h1 |=> octet_alarm ##1 octet_alarm)
    else $error("alarm not raised after eight misses");
  rx_alarm_clr_a: assert property (
    rx_oct_done && rx_viol |=> !octet_alarm && rx_miss == 4'h0)
    else $error("violation did not clear alarm");
endmodule : cdp_adapter
`default_nettype wire

// file: verification/cdp_line_partner.sv
// Line interface model: streams one octet on active-low AMI rails.
// Assumes aclk at 100 MHz; one unit interval is 64 aclk cycles.
`timescale 1ns/1ns
`default_nettype none
module cdp_line_partner (
  input wire logic aclk,
  input wire logic [7:0] word,
  input wire logic viol_on,
  output logic rx_pos_n,
  output logic rx_neg_n
);
  logic pol = 1'h0;
  logic mark;
  logic [7:0] cur;
  // ====
  // Octet stream, MSB first
  always begin
    cur = word;
    for (int i = 7; i >= 0; i--) begin
      if (i != 0 || !viol_on) begin
        pol = !pol;
      end
      for (int u = 0; u < 4; u++) begin
        mark = (u == 0) || (cur[i] ? u == 1 : u == 2);
        @(posedge aclk);
        rx_pos_n <= !(mark && pol);
        rx_neg_n <= !(mark && !pol);
        repeat (63) @(posedge aclk);
      end
    end
  end
endmodule : cdp_line_partner
`default_nettype wire

// file: verification/testbench.sv
// Bench for the slot adapter: registers, transmit coding, receive slots.
// Assumes the line partner model; pin clocks come from an aclk counter.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import cdp_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, cyc = 8'h00, word = 8'hA5;
  logic [31:0] wdata = 32'h0, q, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic bck = 1'h0, lck = 1'h0, tx_din = 1'h0, tx_sa = 1'h0, rx_sa = 1'h0, viol_on = 1'h1;
  logic tx_b = 1'h0, rx_b = 1'h0, tx_sb = 1'h0, rx_sb = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, tx_p, tx_n, rx_p, rx_n, rx_out, alarm;
  logic [1:0] bresp, rresp;
  int err_count = 0;
  int n_tests = 0;
  int tmo = 0;
  cdp_adapter dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_tdm_serial_in(tx_din), .tx_bit_clock(bck), .tx_slot_a(tx_sa), .tx_slot_b(tx_sb),
    .tx_line_clock(lck), .tx_pos_n(tx_p), .tx_neg_n(tx_n), .rx_pos_n(rx_p), .rx_neg_n(rx_n),
    .rx_recovery_clock(bck), .rx_bit_clock(bck), .rx_slot_a(rx_sa), .rx_slot_b(rx_sb),
    .rx_tdm_serial_out(rx_out), .octet_alarm(alarm)
  );
  cdp_line_partner line (.aclk(aclk), .word(word), .viol_on(viol_on), .rx_pos_n(rx_p), .rx_neg_n(rx_n));
  // ====
  // Clocks and timeout
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 8'h01;
    bck <= cyc[2];
    lck <= cyc[3];
    tmo <= tmo + 1;
    if (tmo == 60000) begin
      err_count++;
      results();
    end
  end
  // ====
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic results();
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'h1;
    w = 1'h1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      aw = aw && !awready;
      w = w && !wready;
      awvalid <= aw;
      wvalid <= w;
    end while (aw || w || !bvalid);
    bready <= 1'h0;
    chk("bresp", bresp, er);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ar;
    ar = 1'h1;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      ar = ar && !arready;
      arvalid <= ar;
    end while (ar || !rvalid);
    rready <= 1'h0;
    d = rdata;
    chk("rresp", rresp, er);
  endtask : axi_rd
  // Envelope rises with a bit clock fall
  task automatic tx_slot(input logic [7:0] d);
    do @(posedge aclk); while (cyc[2:0] != 3'h0);
    tx_sa <= !tx_b;
    tx_sb <= tx_b;
    for (int i = 7; i >= 0; i--) begin
      tx_din <= d[i];
      repeat (8) @(posedge aclk);
    end
    tx_sa <= 1'h0;
    tx_sb <= 1'h0;
  endtask : tx_slot
  // Samples 16 blocks mid unit interval
  task automatic tx_check(input logic [15:0] d, input logic alm);
    logic [3:0] pp [16];
    logic [3:0] pn [16];
    logic [15:0] pv;
    while (tx_p && tx_n) @(posedge aclk);
    repeat (8) @(posedge aclk);
    for (int k = 0; k < 16; k++) begin
      for (int u = 3; u >= 0; u--) begin
        pp[k][u] = tx_p;
        pn[k][u] = tx_n;
        repeat (16) @(posedge aclk);
      end
    end
    for (int k = 0; k < 16; k++) begin
      pv[k] = pp[k] != 4'hF;
      chk("tx_quiet", pv[k] ? pn[k] : pp[k], 4'hF);
      chk("tx_code", pv[k] ? pp[k] : pn[k], d[15 - k] ? 4'h3 : 4'h5);
      if (k > 0) begin
        chk("tx_pol", pv[k] ^ pv[k - 1], !(k % 8 == 7 && !alm));
      end
    end
  endtask : tx_check
  // Envelope rises with a bit clock rise
  task automatic rx_exp(input int n, input logic [7:0] e);
    logic [7:0] r;
    repeat (n * 2048) @(posedge aclk);
    do @(posedge aclk); while (cyc[2:0] != 3'h4);
    rx_sa <= !rx_b;
    rx_sb <= rx_b;
    for (int i = 7; i >= 0; i--) begin
      repeat (7) @(posedge aclk);
      r[i] = rx_out;
      if (i > 0) @(posedge aclk);
    end
    rx_sa <= 1'h0;
    rx_sb <= 1'h0;
    chk("rx_octet", r, e);
  endtask : rx_exp
  // ====
  // Scenarios
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(CDP_ADDR_CTRL, CDP_RESP_OKAY, q);
    chk("ctrl", q, 32'h13);
    axi_rd(8'h08, CDP_RESP_SLVERR, q);
    chk("unmapped", q, 32'h0);
    axi_wr(8'h0C, 32'h0, CDP_RESP_SLVERR);
    tx_slot(8'hA5);
    tx_check(16'hA5A5, 1'h0);
    chk("tx_idle", {tx_p, tx_n}, 2'h3);
    axi_rd(CDP_ADDR_STAT, CDP_RESP_OKAY, q);
    chk("stat_tx", q[3:2], 2'h3);
    axi_wr(CDP_ADDR_CTRL, 32'h17, CDP_RESP_OKAY);
    fork
      tx_check(16'hC35A, 1'h1);
      begin
        tx_slot(8'hC3);
        tx_slot(8'h96);
        tx_slot(8'h5A);
      end
    join
    rx_exp(1, 8'hA5);
    word <= 8'h3C;
    rx_exp(3, 8'h3C);
    rx_exp(0, 8'h3C);
    axi_wr(CDP_ADDR_CTRL, 32'h1B, CDP_RESP_OKAY);
    rx_exp(0, 8'hFF);
    axi_wr(CDP_ADDR_CTRL, 32'h13, CDP_RESP_OKAY);
    viol_on <= 1'h0;
    rx_exp(3, 8'h3C);
    chk("alarm_early", alarm, 1'h0);
    repeat (7 * 2048) @(posedge aclk);
    chk("alarm", alarm, 1'h1);
    axi_rd(CDP_ADDR_STAT, CDP_RESP_OKAY, q);
    chk("stat_alarm", q[1:0], 2'h1);
    axi_wr(CDP_ADDR_CTRL, 32'h03, CDP_RESP_OKAY);
    rx_exp(1, 8'hFF);
    viol_on <= 1'h1;
    rx_exp(3, 8'h3C);
    chk("alarm_clear", alarm, 1'h0);
    axi_wr(CDP_ADDR_CTRL, 32'h30, CDP_RESP_OKAY);
    tx_b <= 1'h1;
    rx_b <= 1'h1;
    tx_slot(8'h69);
    tx_check(16'h6969, 1'h0);
    rx_exp(1, 8'h3C);
    results();
  end
endmodule : testbench
`default_nettype wire
